// ===== design/irq_vector_priority_bank0.v
// Purpose: bank-0 interrupt flags and enables, priority pick and vector address
// Assumes: single 10 MHz clock mclk, plain register port with read data one cycle later
// Notes: software traps may request any number 0..31 through the trap port
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "irq_consts.vh"
module irq_vector_priority_bank0 #(
	parameter ADDR_W = `IRQ_ADDR_W
) (
	input  wire                     mclk,
	input  wire                     rst_n,
	// register port
	input  wire [`REG_ADDR_W-1:0]   regAddr,
	input  wire [15:0]              regWdata,
	input  wire                     regWr,
	input  wire                     regRd,
	output reg  [15:0]              regRdata_q,
	// source events, one-cycle pulses
	input  wire                     extUserIrqA,
	input  wire                     extUserIrqB,
	input  wire                     timerAggIrq,
	input  wire                     mmc0Irq,
	input  wire                     i2s0TxIrq,
	input  wire                     mmc0SdioIrq,
	input  wire                     i2s0RxIrq,
	input  wire                     mmc1Irq,
	input  wire                     i2s1TxIrq,
	input  wire                     mmc1SdioIrq,
	input  wire                     i2s1RxIrq,
	input  wire                     uartIrq,
	input  wire                     dmaAggIrq,
	input  wire                     lcdIrq,
	input  wire                     adcConvIrq,
	input  wire                     serial2TxIrq,
	input  wire                     serial2RxIrq,
	// reset and software trap from the cpu
	input  wire                     softReset,
	input  wire                     trapReq,
	input  wire [`IRQ_NUM_W-1:0]    trapNum,
	// cpu side
	input  wire                     cpuAck,
	output reg                      cpuIrq_q,
	output reg  [`IRQ_NUM_W-1:0]    cpuIrqNum_q,
	output reg  [`IRQ_PRIO_W-1:0]   cpuIrqPrio_q,
	output reg  [ADDR_W-1:0]        cpuVecAddr_q,
	output wire                     nmiActive
);
	reg  [15:0]              flag_q;
	reg  [15:0]              flag_d;
	reg  [15:0]              enable_q;
	reg  [ADDR_W-1:0]        vbaseLow_q;
	reg  [ADDR_W-1:0]        vbaseHigh_q;
	reg  [1:0]               port0Mux_q;
	reg  [1:0]               port1Mux_q;
	reg                      rstPend_q;
	wire [15:0]              events;
	wire [15:0]              pending;
	wire                     found;
	wire [`IRQ_NUM_W-1:0]    winNum;
	wire [`IRQ_PRIO_W-1:0]   winPrio;
	reg  [`IRQ_NUM_W-1:0]    selNum;
	reg  [`IRQ_PRIO_W-1:0]   selPrio;
	reg                      selValid;

	// nonmaskable input is not asserted inside the chip
	assign nmiActive = 1'b0;

	// port-0 mux select: 00 mmc, 01 i2s; port 1 analogous
	function muxPick;
		input [1:0] sel;
		input       mmcSrc;
		input       i2sSrc;
		begin
			case (sel)
				`MUX_MMC: muxPick = mmcSrc;
				`MUX_I2S: muxPick = i2sSrc;
				default:  muxPick = 1'b0;
			endcase
		end
	endfunction

	// flag and enable share one layout
	assign events[1:0]            = 2'h0;
	assign events[`BIT_EXT_A]     = extUserIrqA;
	assign events[`BIT_EXT_B]     = extUserIrqB;
	assign events[`BIT_TIMER]     = timerAggIrq;
	assign events[`BIT_PROG_TX_A] = muxPick(port0Mux_q, mmc0Irq, i2s0TxIrq);
	assign events[`BIT_UART]      = uartIrq;
	assign events[`BIT_PROG_RX_A] = muxPick(port0Mux_q, mmc0SdioIrq, i2s0RxIrq);
	assign events[`BIT_DMA]       = dmaAggIrq;
	assign events[`BIT_PROG_TX_B] = muxPick(port1Mux_q, mmc1Irq, i2s1TxIrq);
	assign events[`BIT_RSVD]      = 1'b0;
	assign events[`BIT_PROG_RX_B] = muxPick(port1Mux_q, mmc1SdioIrq, i2s1RxIrq);
	assign events[`BIT_LCD]       = lcdIrq;
	assign events[`BIT_ADC]       = adcConvIrq;
	assign events[`BIT_SER2_TX]   = serial2TxIrq;
	assign events[`BIT_SER2_RX]   = serial2RxIrq;

	// only flagged and enabled bits request
	assign pending = flag_q & enable_q;

	irq_prio_pick u_pick (
		.pending (pending),
		.found   (found),
		.winNum  (winNum),
		.winPrio (winPrio)
	);

	// absolute vector: base plus eight times the number
	function [ADDR_W-1:0] vecAddr;
		input [`IRQ_NUM_W-1:0] num;
		input [ADDR_W-1:0]     lowBase;
		input [ADDR_W-1:0]     highBase;
		reg   [ADDR_W-1:0]     off;
		begin
			off = {{(ADDR_W-`IRQ_NUM_W){1'b0}}, num} << `IRQ_VEC_SHIFT;
			if (num >= `IRQ_HIGH_FIRST && num <= `IRQ_HIGH_LAST)
				vecAddr = highBase + off;
			else
				vecAddr = lowBase + off;
		end
	endfunction

	// software trap priority for any number 0..31, bank 0 included
	function [`IRQ_PRIO_W-1:0] trapPrio;
		input [`IRQ_NUM_W-1:0] n;
		begin
			case (n)
				5'd0:    trapPrio = 5'd0;
				5'd1:    trapPrio = 5'd1;
				5'd2:    trapPrio = 5'd3;
				5'd3:    trapPrio = 5'd5;
				5'd4:    trapPrio = 5'd6;
				5'd5:    trapPrio = 5'd7;
				5'd6:    trapPrio = 5'd9;
				5'd7:    trapPrio = 5'd10;
				5'd8:    trapPrio = 5'd11;
				5'd9:    trapPrio = 5'd13;
				5'd10:   trapPrio = 5'd14;
				5'd11:   trapPrio = 5'd15;
				5'd12:   trapPrio = 5'd17;
				5'd13:   trapPrio = 5'd18;
				5'd14:   trapPrio = 5'd21;
				5'd15:   trapPrio = 5'd22;
				5'd16:   trapPrio = 5'd4;
				5'd17:   trapPrio = 5'd8;
				5'd18:   trapPrio = 5'd12;
				5'd19:   trapPrio = 5'd16;
				5'd20:   trapPrio = 5'd19;
				5'd21:   trapPrio = 5'd20;
				5'd22:   trapPrio = 5'd23;
				5'd23:   trapPrio = 5'd24;
				5'd24:   trapPrio = 5'd2;
				5'd25:   trapPrio = 5'd25;
				5'd26:   trapPrio = 5'd26;
				5'd27:   trapPrio = 5'd14;
				5'd28:   trapPrio = 5'd15;
				5'd29:   trapPrio = 5'd16;
				5'd30:   trapPrio = 5'd17;
				default: trapPrio = 5'd18;
			endcase
		end
	endfunction

	// reset request beats traps, traps beat hardware requests
	always @* begin
		selValid = found;
		selNum   = winNum;
		selPrio  = winPrio;
		if (rstPend_q) begin
			selValid = 1'b1;
			selNum   = `IRQ_NONE_NUM;
			selPrio  = trapPrio(`IRQ_NONE_NUM);
		end else if (trapReq) begin
			selValid = 1'b1;
			selNum   = trapNum;
			selPrio  = trapPrio(trapNum);
		end else if (found) begin
			selNum  = winNum;
			selPrio = winPrio;
		end
	end

	// flags: a new event wins over a write-one clear; ack clears the winner
	always @* begin
		flag_d = flag_q;
		if (regWr && regAddr == `REG_FLAG0)
			flag_d = flag_d & ~(regWdata & `IRQ_BANK0_WMASK);
		if (cpuAck && cpuIrq_q && cpuIrqNum_q < `IRQ_BANK0_NUMS)
			flag_d[cpuIrqNum_q[3:0]] = 1'b0;
		flag_d = (flag_d | events) & `IRQ_BANK0_WMASK;
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q       <= `IRQ_BANK0_RESET;
			enable_q     <= `IRQ_BANK0_RESET;
			vbaseLow_q   <= {ADDR_W{1'b0}};
			vbaseHigh_q  <= {ADDR_W{1'b0}};
			port0Mux_q   <= `MUX_MMC;
			port1Mux_q   <= `MUX_MMC;
			rstPend_q    <= 1'b0;
			cpuIrq_q     <= 1'b0;
			cpuIrqNum_q  <= `IRQ_NONE_NUM;
			cpuIrqPrio_q <= `IRQ_PRIO_NONE;
			cpuVecAddr_q <= {ADDR_W{1'b0}};
			regRdata_q   <= 16'h0000;
		end else begin
			flag_q <= flag_d;
			if (regWr) begin
				case (regAddr)
					`REG_ENABLE0:    enable_q <= regWdata & `IRQ_BANK0_WMASK;
					`REG_VBASE_LOW:  vbaseLow_q <= {{(ADDR_W-16){1'b0}}, regWdata};
					`REG_VBASE_HIGH: vbaseHigh_q <= {{(ADDR_W-16){1'b0}}, regWdata};
					`REG_PORT0_MUX: begin
						port0Mux_q <= regWdata[1:0];
						port1Mux_q <= regWdata[3:2];
					end
					default: ;
				endcase
			end
			if (softReset)
				rstPend_q <= 1'b1;
			else if (cpuAck && cpuIrq_q && cpuIrqNum_q == `IRQ_NONE_NUM)
				rstPend_q <= 1'b0;
			cpuIrq_q     <= selValid;
			cpuIrqNum_q  <= selNum;
			cpuIrqPrio_q <= selPrio;
			cpuVecAddr_q <= vecAddr(selNum, vbaseLow_q, vbaseHigh_q);
			regRdata_q   <= 16'h0000;
			if (regRd) begin
				case (regAddr)
					`REG_FLAG0:      regRdata_q <= flag_q;
					`REG_ENABLE0:    regRdata_q <= enable_q;
					`REG_VBASE_LOW:  regRdata_q <= vbaseLow_q[15:0];
					`REG_VBASE_HIGH: regRdata_q <= vbaseHigh_q[15:0];
					`REG_PORT0_MUX:  regRdata_q <= {12'h000, port1Mux_q, port0Mux_q};
					`REG_WINNER:     regRdata_q <= {5'h00, found, winPrio, winNum};
					default:         regRdata_q <= 16'h0000;
				endcase
			end
		end
	end
endmodule // irq_vector_priority_bank0

// ===== design/irq_consts.vh
// Purpose: constants for the interrupt vector and priority block
// Assumes: 16-bit register port, byte offsets for vectors
// Notes: register indices of the plain port are local choices
`ifndef IRQ_VECTOR_CONSTS_VH
`define IRQ_VECTOR_CONSTS_VH

`define IRQ_NUM_W        5
`define IRQ_PRIO_W       5
`define IRQ_VEC_SHIFT    3
`define IRQ_ADDR_W       24
`define IRQ_BANK0_RESET  16'h0000
`define IRQ_BANK0_WMASK  16'hfbfc
// low vector base covers 0..15 and 24..31, high base covers 16..23
`define IRQ_HIGH_FIRST   5'h10
`define IRQ_HIGH_LAST    5'h17
`define IRQ_PRIO_NONE    5'h1f
`define IRQ_NONE_NUM     5'h00
// numbers below this one own a flag bit in bank 0
`define IRQ_BANK0_NUMS   5'h10

// register indices on the plain port
`define REG_FLAG0        3'h0
`define REG_ENABLE0      3'h1
`define REG_VBASE_LOW    3'h2
`define REG_VBASE_HIGH   3'h3
`define REG_PORT0_MUX    3'h4
`define REG_WINNER       3'h5
`define REG_ADDR_W       3

// port-0 mux encodings
`define MUX_MMC          2'h0
`define MUX_I2S          2'h1

// bit positions of bank 0
`define BIT_EXT_A        2
`define BIT_EXT_B        3
`define BIT_TIMER        4
`define BIT_PROG_TX_A    5
`define BIT_UART         6
`define BIT_PROG_RX_A    7
`define BIT_DMA          8
`define BIT_PROG_TX_B    9
`define BIT_RSVD         10
`define BIT_PROG_RX_B    11
`define BIT_LCD          12
`define BIT_ADC          13
`define BIT_SER2_TX      14
`define BIT_SER2_RX      15

`endif

// ===== design/irq_prio_pick.v
// Purpose: pick the enabled pending bank-0 request with the smallest priority value
// Assumes: pending vector is flag and enable already combined
// Notes: bit 1..0 and 10 never request; ties cannot occur in this bank
`timescale 1ns/1ps
`include "irq_consts.vh"
module irq_prio_pick (
	input  wire [15:0]              pending,
	output reg                      found,
	output reg  [`IRQ_NUM_W-1:0]    winNum,
	output reg  [`IRQ_PRIO_W-1:0]   winPrio
);
	// interrupt number of a bank-0 bit equals the bit position
	function [`IRQ_PRIO_W-1:0] bitPrio;
		input [3:0] b;
		begin
			case (b)
				4'h2:    bitPrio = 5'd3;
				4'h3:    bitPrio = 5'd5;
				4'h4:    bitPrio = 5'd6;
				4'h5:    bitPrio = 5'd7;
				4'h6:    bitPrio = 5'd9;
				4'h7:    bitPrio = 5'd10;
				4'h8:    bitPrio = 5'd11;
				4'h9:    bitPrio = 5'd13;
				4'hb:    bitPrio = 5'd15;
				4'hc:    bitPrio = 5'd17;
				4'hd:    bitPrio = 5'd18;
				4'he:    bitPrio = 5'd21;
				4'hf:    bitPrio = 5'd22;
				default: bitPrio = `IRQ_PRIO_NONE;
			endcase
		end
	endfunction

	integer i;
	always @* begin
		found   = 1'b0;
		winNum  = `IRQ_NONE_NUM;
		winPrio = `IRQ_PRIO_NONE;
		for (i = 0; i < 16; i = i + 1) begin
			if (pending[i] && (bitPrio(i[3:0]) < winPrio)) begin
				found   = 1'b1;
				winNum  = i[`IRQ_NUM_W-1:0];
				winPrio = bitPrio(i[3:0]);
			end
		end
	end
endmodule // irq_prio_pick

// ===== sim/irq_bank0_asserts.sv
// Purpose: port checks of the bank-0 interrupt block
// Assumes: bases and enables mirrored from register writes
// Notes: trap and reset requests outrank bank 0
`timescale 1ns/1ps
module irq_bank0_asserts #(
	parameter ADDR_W = 24
) (
	input wire		mclk,
	input wire		rst_n,
	input wire [2:0]	regAddr,
	input wire [15:0]	regWdata,
	input wire		regWr,
	input wire		regRd,
	input wire [15:0]	regRdata_q,
	input wire		extUserIrqA,
	input wire		softReset,
	input wire		trapReq,
	input wire [4:0]	trapNum,
	input wire		cpuAck,
	input wire		cpuIrq_q,
	input wire [4:0]	cpuIrqNum_q,
	input wire [4:0]	cpuIrqPrio_q,
	input wire [ADDR_W-1:0]	cpuVecAddr_q,
	input wire		nmiActive
);
	localparam bit [4:0] PRIO [32] = '{0, 1, 3, 5, 6, 7, 9, 10, 11, 13, 14, 15, 17, 18, 21,
		22, 4, 8, 12, 16, 19, 20, 23, 24, 2, 25, 26, 14, 15, 16, 17, 18};
	reg [15:0]		loB;
	reg [15:0]		hiB;
	reg [15:0]		enQ;
	reg [15:0]		enP;
	reg			rstM;
	wire			hiSel = cpuIrqNum_q >= 5'h10 && cpuIrqNum_q <= 5'h17;
	wire [ADDR_W-1:0]	off = {{(ADDR_W-8){1'b0}}, cpuIrqNum_q, 3'h0};
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			loB <= 16'h0;
			hiB <= 16'h0;
			enQ <= 16'h0;
		end else if (regWr) begin
			if (regAddr == 3'h1) enQ <= regWdata & 16'hfbfc;
			if (regAddr == 3'h2) loB <= regWdata;
			if (regAddr == 3'h3) hiB <= regWdata;
		end
	end
	// enP is the enable seen when the presented request was chosen; rstM mirrors a pending reset
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			enP <= 16'h0;
			rstM <= 1'b0;
		end else begin
			enP <= enQ;
			if (softReset) rstM <= 1'b1;
			else if (cpuAck && cpuIrq_q && cpuIrqNum_q == 5'h0) rstM <= 1'b0;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	nmi_tied_a: assert property (nmiActive == 1'b0)
		else $error("nmi line active");
	rd_idle_a: assert property (!$past(regRd) |-> regRdata_q == 16'h0)
		else $error("read data outside slot");
	rd_rsvd_a: assert property ($past(regRd) && $past(regAddr) <= 3'h1
		|-> regRdata_q[1:0] == 2'h0 && !regRdata_q[10]) else $error("reserved bit set");
	prio_map_a: assert property (cpuIrq_q |-> cpuIrqPrio_q == PRIO[cpuIrqNum_q])
		else $error("wrong priority");
	vec_addr_a: assert property (cpuIrq_q |-> cpuVecAddr_q == off
		+ (hiSel ? ADDR_W'($past(hiB)) : ADDR_W'($past(loB)))) else $error("wrong vector");
	ev_latency_a: assert property (extUserIrqA && enQ[2] |-> ##2 cpuIrq_q)
		else $error("request late");
	need_enable_a: assert property (cpuIrq_q && cpuIrqNum_q >= 5'h2 &&
		cpuIrqNum_q <= 5'hf && !$past(trapReq) |-> enP[cpuIrqNum_q[3:0]])
		else $error("request without enable");
	trap_take_a: assert property (trapReq && !softReset && !rstM
		|=> cpuIrq_q && cpuIrqNum_q == $past(trapNum)) else $error("trap not taken");
	reset_take_a: assert property (softReset
		|-> ##[1:2] (cpuIrq_q && cpuIrqNum_q == 5'h0 && cpuIrqPrio_q == 5'h0))
		else $error("reset not taken");
endmodule // irq_bank0_asserts

bind irq_vector_priority_bank0 irq_bank0_asserts #(.ADDR_W(ADDR_W)) chk (.mclk(mclk),
	.rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
	.regRd(regRd), .regRdata_q(regRdata_q), .extUserIrqA(extUserIrqA),
	.softReset(softReset), .trapReq(trapReq), .trapNum(trapNum), .cpuAck(cpuAck),
	.cpuIrq_q(cpuIrq_q),
	.cpuIrqNum_q(cpuIrqNum_q), .cpuIrqPrio_q(cpuIrqPrio_q),
	.cpuVecAddr_q(cpuVecAddr_q), .nmiActive(nmiActive));

// ===== sim/irq_cpu_model.sv
// Purpose: cpu side that takes requests and acknowledges them
// Assumes: lag cycles of think time before each acknowledge
// Notes: holds off until the block has re-evaluated its winner
`timescale 1ns/1ps
module irq_cpu_model (
	input wire		mclk,
	input wire		rst_n,
	input wire		ackEn,
	input wire [3:0]	lag,
	input wire		cpuIrq_q,
	input wire [4:0]	cpuIrqNum_q,
	output reg		cpuAck
);
	int		took[$];
	reg [4:0]	cnt;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpuAck <= 1'b0;
			cnt <= 5'h0;
		end else begin
			cpuAck <= 1'b0;
			if (cpuAck) took.push_back(cpuIrqNum_q);
			if (cnt == 5'h0) begin
				if (ackEn && cpuIrq_q) cnt <= 5'h4 + {1'b0, lag};
			end else begin
				cnt <= cnt - 5'h1;
				if (cnt == 5'h4) cpuAck <= 1'b1;
			end
		end
	end
endmodule // irq_cpu_model

// ===== sim/irq_vector_priority_bank0_tb.sv
// Purpose: scenario bench for the bank-0 interrupt block
// Assumes: cpu model acknowledges, bench drives sources
// Notes: ev drives direct and mmc sources, alt the i2s ones
`timescale 1ns/1ps
module irq_vector_priority_bank0_tb;
	localparam [23:0] LO = 24'h1000;
	localparam [23:0] HI = 24'h2000;
	reg		mclk, rst_n, regWr, regRd, softReset, trapReq, ackEn;
	reg [2:0]	regAddr;
	reg [15:0]	regWdata, ev, alt;
	reg [4:0]	trapNum;
	reg [3:0]	lag;
	wire		cpuAck, cpuIrq_q, nmi;
	wire [15:0]	regRdata_q;
	wire [4:0]	cpuIrqNum_q, cpuIrqPrio_q;
	wire [23:0]	cpuVecAddr_q;
	int		n_mismatch = 0, n_compared = 0, cyc = 0;
	irq_vector_priority_bank0 dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q),
		.extUserIrqA(ev[2]), .extUserIrqB(ev[3]), .timerAggIrq(ev[4]), .mmc0Irq(ev[5]),
		.i2s0TxIrq(alt[5]), .mmc0SdioIrq(ev[7]), .i2s0RxIrq(alt[7]), .mmc1Irq(ev[9]),
		.i2s1TxIrq(alt[9]), .mmc1SdioIrq(ev[11]), .i2s1RxIrq(alt[11]), .uartIrq(ev[6]),
		.dmaAggIrq(ev[8]), .lcdIrq(ev[12]), .adcConvIrq(ev[13]), .serial2TxIrq(ev[14]),
		.serial2RxIrq(ev[15]), .softReset(softReset), .trapReq(trapReq),
		.trapNum(trapNum), .cpuAck(cpuAck), .cpuIrq_q(cpuIrq_q),
		.cpuIrqNum_q(cpuIrqNum_q), .cpuIrqPrio_q(cpuIrqPrio_q),
		.cpuVecAddr_q(cpuVecAddr_q), .nmiActive(nmi));
	irq_cpu_model cpu (.mclk(mclk), .rst_n(rst_n), .ackEn(ackEn), .lag(lag),
		.cpuIrq_q(cpuIrq_q), .cpuIrqNum_q(cpuIrqNum_q), .cpuAck(cpuAck));
	initial mclk = 1'b0;
	always #50 mclk = ~mclk;
	task stop_test;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			stop_test;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input [2:0] a, input [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task rd(input [2:0] a, input [15:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 chk(regRdata_q, e);
	endtask
	task pulse(input [15:0] e, input [15:0] a);
		@(posedge mclk);
		ev <= e;
		alt <= a;
		@(posedge mclk);
		ev <= 16'h0;
		alt <= 16'h0;
	endtask
	task cpuChk(input [4:0] n, input [4:0] p, input [23:0] v);
		chk(cpuIrq_q, 1);
		chk(cpuIrqNum_q, n);
		chk(cpuIrqPrio_q, p);
		chk(cpuVecAddr_q, v);
	endtask
	task t_regs;
		rd(3'h0, 16'h0);
		chk(nmi, 0);
		chk(cpuIrqPrio_q, 5'h1f);
		wr(3'h1, 16'hfbff);
		rd(3'h1, 16'hfbfc);
		wr(3'h1, 16'h0);
		rd(3'h6, 16'h0);
		wr(3'h2, LO[15:0]);
		wr(3'h3, HI[15:0]);
		rd(3'h2, LO[15:0]);
		rd(3'h3, HI[15:0]);
	endtask
	task t_flag;
		pulse(16'h000c, 16'h0);
		rd(3'h0, 16'h000c);
		chk(cpuIrq_q, 0);
		wr(3'h0, 16'h0008);
		rd(3'h0, 16'h0004);
		wr(3'h1, 16'h0004);
		repeat (2) @(posedge mclk);
		#1 cpuChk(5'h2, 5'h3, LO + 24'h10);
		rd(3'h5, 16'h0462);
		wr(3'h0, 16'h0004);
		repeat (2) @(posedge mclk);
		#1 chk(cpuIrq_q, 0);
		wr(3'h1, 16'h0);
	endtask
	task t_mux;
		for (int s = 0; s < 3; s++) begin
			wr(3'h4, (s == 0) ? 16'h0 : (s == 1) ? 16'h0005 : 16'h000a);
			rd(3'h4, (s == 0) ? 16'h0 : (s == 1) ? 16'h0005 : 16'h000a);
			pulse(16'h0aa0, 16'h0);
			rd(3'h0, (s == 0) ? 16'h0aa0 : 16'h0);
			wr(3'h0, 16'hfbfc);
			pulse(16'h0, 16'h0aa0);
			rd(3'h0, (s == 1) ? 16'h0aa0 : 16'h0);
			wr(3'h0, 16'hfbfc);
		end
		wr(3'h4, 16'h0);
	endtask
	task t_prio;
		int exp[5] = '{2, 3, 5, 6, 13};
		lag <= 4'h0;
		ackEn <= 1'b1;
		wr(3'h1, 16'hfbfc);
		pulse(16'h206c, 16'h0);
		for (int i = 0; i < 80 && cpu.took.size() < 5; i++) @(posedge mclk);
		ackEn <= 1'b0;
		for (int i = 0; i < 5; i++) chk(cpu.took[i], exp[i]);
		rd(3'h0, 16'h0);
		wr(3'h1, 16'h0);
	endtask
	task t_trap;
		bit [4:0] nums[5] = '{1, 18, 26, 31, 11};
		bit [4:0] prs[5] = '{1, 12, 26, 18, 15};
		for (int i = 0; i < 5; i++) begin
			@(posedge mclk);
			trapReq <= 1'b1;
			trapNum <= nums[i];
			repeat (2) @(posedge mclk);
			#1 cpuChk(nums[i], prs[i], (nums[i] == 5'd18 ? HI : LO) + {nums[i], 3'h0});
			@(posedge mclk);
			trapReq <= 1'b0;
		end
	endtask
	task t_reset;
		lag <= 4'h5;
		ackEn <= 1'b1;
		@(posedge mclk);
		softReset <= 1'b1;
		@(posedge mclk);
		softReset <= 1'b0;
		@(posedge mclk);
		#1 cpuChk(5'h0, 5'h0, LO);
		for (int i = 0; i < 40 && cpu.took.size() < 6; i++) @(posedge mclk);
		chk(cpu.took[5], 0);
		repeat (3) @(posedge mclk);
		#1 chk(cpuIrq_q, 0);
		ackEn <= 1'b0;
	endtask
	task t_hwrst;
		wr(3'h1, 16'hfbfc);
		pulse(16'h000c, 16'h0);
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd(3'h0, 16'h0);
		rd(3'h1, 16'h0);
		rd(3'h2, 16'h0);
		chk(cpuIrq_q, 0);
	endtask
	initial begin
		{rst_n, regWr, regRd, softReset, trapReq, ackEn} = 6'h0;
		{regAddr, regWdata, ev, alt, trapNum, lag} = 60'h0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs;
		t_flag;
		t_mux;
		t_prio;
		t_trap;
		t_reset;
		t_hwrst;
		stop_test;
	end
endmodule // irq_vector_priority_bank0_tb
